// ===== pts_top.sv
// Pulse-per-second time sync selector with AXI4-Lite registers
// Behaviour
// R01 - Reference pulse enters on circuit A receive
// R02 - Master drives its pulse on circuit A transmit
// R03 - Valid pulse on selected port locks automatically
// R04 - Unconfigured card defaults to slave role
// R05 - No input: free-run, report not synchronized
// R06 - Host input and internal output together allowed
// R07 - Host loads time within one second first (no time register here; IN_HOST locks on HOST_TICK alone)
// R08 - Readable pulse statistics, phase health threshold
// R09 - Full reset: port input, no output
// R10 - Internal input follows host-derived tick
// R11 - Internal output drives own generated pulse
// R12 - Two-stage synchronizer, one action per edge
`timescale 1ns/1ns
module pts_top #(
	parameter int CYCLES_PER_SEC = pts_pkg::PPS_CYCLES,
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Sync port circuit A
	input wire logic PPS_RX_A,
	output logic PPS_TX_A,
	output logic PPS_TX_A_OE,
	// Host-derived second tick
	input wire logic HOST_TICK,
	// Interrupt
	output logic IRQ
);
	localparam int CW = $clog2(CYCLES_PER_SEC);
	localparam logic [CW-1:0] LAST_CNT = CW'(CYCLES_PER_SEC - 1);
	localparam logic [CW-1:0] HALF_CNT = CW'(CYCLES_PER_SEC / 2);
	localparam logic [CW:0] BAD_GAP = (CW+1)'(CYCLES_PER_SEC / 2);
	localparam logic [CW:0] MISS_GAP = (CW+1)'(CYCLES_PER_SEC + CYCLES_PER_SEC / 2);
	localparam logic [CW:0] MISS_RELOAD = (CW+1)'(CYCLES_PER_SEC / 2);
	localparam logic [15:0] PULSE_LEN = 16'(pts_pkg::PULSE_CYCLES);

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		return res;
	endfunction

	// Phase offset in cycles to nanoseconds
	function automatic logic [31:0] to_ns(input logic [CW-1:0] cyc);
		return 32'(cyc) * 32'(pts_pkg::CLK_PERIOD_NS);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [1:0] in_sel_r, out_sel_r;
	logic [31:0] thresh_r, phase_r;
	logic [pts_pkg::IRQ_W-1:0] int_sts_r, int_mask_r;
	pts_pkg::pts_sync_e state_r, state_nxt;
	logic [CW-1:0] sec_cnt_r;
	logic [CW:0] gap_r;
	logic seen_r;
	logic [15:0] pulse_cnt_r;
	logic tx_r, oe_r;
	logic rx_level, rx_rise;
	pts_stat_if st();

	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes and decode

	wire wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
	wire ar_take = S_AXI_ARVALID & ~rvalid_r;
	wire wr_ctrl = wr_go & (awaddr_r == ADDR_W'(pts_pkg::REG_CTRL));
	wire wr_thresh = wr_go & (awaddr_r == ADDR_W'(pts_pkg::REG_THRESH));
	wire wr_ists = wr_go & (awaddr_r == ADDR_W'(pts_pkg::REG_INT_STS));
	wire wr_imask = wr_go & (awaddr_r == ADDR_W'(pts_pkg::REG_INT_MASK));
	wire wr_ro = wr_go & (awaddr_r <= ADDR_W'(pts_pkg::REG_PHASE)) & (awaddr_r[1:0] == 2'h0);
	wire ctrl_lane = wr_ctrl & wstrb_r[0];
	wire clr_stats = ctrl_lane & wdata_r[pts_pkg::CTRL_CLR_BIT];
	wire full_rst = ctrl_lane & wdata_r[pts_pkg::CTRL_RST_BIT];

	assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
	assign S_AXI_WREADY = ~w_hold_r & ~bvalid_r;
	assign S_AXI_ARREADY = ~rvalid_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

	// Write channel capture and response
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= pts_pkg::RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ro ? pts_pkg::RESP_OKAY : pts_pkg::RESP_SLVERR;
			end
			else if (bvalid_r && S_AXI_BREADY)
				bvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data selection

	wire [31:0] status_word = {26'h0, state_r, 1'b0,
		out_sel_r == pts_pkg::OUT_INT, state_r == pts_pkg::ST_FREE,
		state_r == pts_pkg::ST_LOCK};
	wire [ADDR_W-1:0] ra = S_AXI_ARADDR;
	wire [31:0] rd_data =
		(ra == ADDR_W'(pts_pkg::REG_CTRL)) ? {28'h0, out_sel_r, in_sel_r} :
		(ra == ADDR_W'(pts_pkg::REG_STATUS)) ? status_word :
		(ra == ADDR_W'(pts_pkg::REG_THRESH)) ? thresh_r :
		(ra == ADDR_W'(pts_pkg::REG_TOTAL)) ? st.total :
		(ra == ADDR_W'(pts_pkg::REG_BAD)) ? st.bad :
		(ra == ADDR_W'(pts_pkg::REG_SINGLES)) ? st.singles :
		(ra == ADDR_W'(pts_pkg::REG_LONGEST)) ? st.longest :
		(ra == ADDR_W'(pts_pkg::REG_FAILS)) ? st.fails :
		(ra == ADDR_W'(pts_pkg::REG_RESYNCS)) ? st.resyncs :
		(ra == ADDR_W'(pts_pkg::REG_INT_STS)) ? {27'h0, int_sts_r} :
		(ra == ADDR_W'(pts_pkg::REG_INT_MASK)) ? {27'h0, int_mask_r} :
		(ra == ADDR_W'(pts_pkg::REG_PHASE)) ? phase_r : 32'h0;
	wire rd_hit = (ra[1:0] == 2'h0) && (ra <= ADDR_W'(pts_pkg::REG_PHASE));

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= pts_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_hit ? rd_data : 32'h0;
			rresp_r <= rd_hit ? pts_pkg::RESP_OKAY : pts_pkg::RESP_SLVERR;
		end
		else if (rvalid_r && S_AXI_RREADY)
			rvalid_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Source selectors, threshold, mask; default is port in, nothing out
	always_ff @(posedge MCLK)
	begin
		if (!NRST || full_rst)
		begin
			in_sel_r <= pts_pkg::IN_PORT; // [R09] [R04]
			out_sel_r <= pts_pkg::OUT_NONE; // [R09]
			if (!NRST)
			begin
				thresh_r <= pts_pkg::THRESH_RST;
				int_mask_r <= '0;
			end
		end
		else
		begin
			if (ctrl_lane)
			begin
				in_sel_r <= wdata_r[pts_pkg::CTRL_IN_LSB +: 2]; // [R06]
				out_sel_r <= wdata_r[pts_pkg::CTRL_OUT_LSB +: 2];
			end
			if (wr_thresh)
				thresh_r <= merge_be(thresh_r, wdata_r, wstrb_r); // [R08]
			if (wr_imask && wstrb_r[0])
				int_mask_r <= wdata_r[pts_pkg::IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reference pulse path

	// Port pulse on receive half of circuit A only; circuit B is not touched here
	pts_edge_sync u_rx_sync (
		.clk(MCLK),
		.rst_n(NRST),
		.din(PPS_RX_A), // [R01]
		.level(rx_level),
		.rise(rx_rise) // [R12]
	);

	// Selected reference and pulse judgement
	wire src_on = (in_sel_r == pts_pkg::IN_PORT) || (in_sel_r == pts_pkg::IN_HOST); // [R05]
	wire ref_tick = (in_sel_r == pts_pkg::IN_PORT) ? rx_rise : // [R03]
		(in_sel_r == pts_pkg::IN_HOST) ? HOST_TICK : 1'b0; // [R10]
	wire bad_pulse = ref_tick & seen_r & (gap_r < BAD_GAP); // [R08]
	wire good_pulse = ref_tick & ~bad_pulse;
	wire miss = src_on & seen_r & ~ref_tick & (gap_r == MISS_GAP); // [R08]
	wire late = sec_cnt_r >= HALF_CNT;
	// Distance from the local second boundary, which falls where the count wraps
	wire [CW-1:0] err_mag = late ? LAST_CNT - sec_cnt_r : sec_cnt_r + CW'(1);
	wire [31:0] err_ns = to_ns(err_mag);
	wire in_thresh = err_ns <= thresh_r; // [R08]
	wire local_tick = good_pulse | (sec_cnt_r == LAST_CNT);

	// Lock state transitions
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			pts_pkg::ST_FREE:
				if (src_on)
					state_nxt = pts_pkg::ST_HUNT;
			pts_pkg::ST_HUNT, pts_pkg::ST_LOST:
				if (good_pulse && in_thresh)
					state_nxt = pts_pkg::ST_LOCK; // [R03]
			pts_pkg::ST_LOCK:
				if (miss || (good_pulse && !in_thresh))
					state_nxt = pts_pkg::ST_LOST;
			default:
				state_nxt = pts_pkg::ST_FREE;
		endcase
		if (!src_on)
			state_nxt = pts_pkg::ST_FREE; // [R05]
	end

	wire ev_fail = (state_r == pts_pkg::ST_LOCK) && (state_nxt == pts_pkg::ST_LOST);
	wire ev_resync = (state_r == pts_pkg::ST_LOST) && (state_nxt == pts_pkg::ST_LOCK);

	// Second counter aligned to each good pulse, gap watchdog, phase capture
	always_ff @(posedge MCLK)
	begin
		if (!NRST || full_rst)
		begin
			state_r <= pts_pkg::ST_FREE;
			sec_cnt_r <= '0;
			gap_r <= '0;
			seen_r <= 1'b0;
			phase_r <= 32'h0;
		end
		else
		begin
			state_r <= state_nxt;
			sec_cnt_r <= (good_pulse || sec_cnt_r == LAST_CNT) ? '0 : sec_cnt_r + CW'(1); // [R03]
			if (!src_on)
			begin
				seen_r <= 1'b0;
				gap_r <= '0;
			end
			else if (good_pulse)
			begin
				seen_r <= 1'b1;
				gap_r <= '0;
				phase_r <= late ? 32'h0 - err_ns : err_ns;
			end
			else if (miss)
				gap_r <= MISS_RELOAD;
			else if (seen_r)
				gap_r <= gap_r + (CW+1)'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pulse output

	// Internally generated pulse of fixed width at each local second
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
			pulse_cnt_r <= 16'h0;
		else if (local_tick)
			pulse_cnt_r <= PULSE_LEN; // [R11]
		else if (pulse_cnt_r != 16'h0)
			pulse_cnt_r <= pulse_cnt_r - 16'h1;
	end

	wire loop_lvl = (in_sel_r == pts_pkg::IN_PORT) ? rx_level :
		(in_sel_r == pts_pkg::IN_HOST) ? HOST_TICK : 1'b0;
	wire tx_nxt = (out_sel_r == pts_pkg::OUT_PORT) ? rx_level :
		(out_sel_r == pts_pkg::OUT_LOOP) ? loop_lvl :
		(out_sel_r == pts_pkg::OUT_INT) ? (pulse_cnt_r != 16'h0) : 1'b0; // [R11] [R06]
	wire oe_nxt = out_sel_r != pts_pkg::OUT_NONE; // [R04] [R09]

	// Registered transmit half of circuit A
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
		begin
			tx_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else
		begin
			tx_r <= tx_nxt; // [R02]
			oe_r <= oe_nxt; // [R02]
		end
	end

	assign PPS_TX_A = tx_r;
	assign PPS_TX_A_OE = oe_r;

	////////////////////////////////////////////////////////////////////////////
	// Statistics and interrupts

	assign st.clear = clr_stats | full_rst;
	assign st.ev_pulse = ref_tick; // [R08]
	assign st.ev_bad = bad_pulse;
	assign st.ev_miss = miss;
	assign st.ev_fail = ev_fail;
	assign st.ev_resync = ev_resync;

	pts_stats u_stats (
		.clk(MCLK),
		.rst_n(NRST),
		.st(st)
	);

	wire [pts_pkg::IRQ_W-1:0] irq_ev = {bad_pulse, ev_resync, ev_fail, miss, good_pulse};
	wire [pts_pkg::IRQ_W-1:0] irq_w1c = (wr_ists && wstrb_r[0]) ?
		wdata_r[pts_pkg::IRQ_W-1:0] : '0;

	// Sticky status, a new event wins over its clear
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
			int_sts_r <= '0;
		else
			int_sts_r <= (int_sts_r & ~irq_w1c) | irq_ev;
	end

	assign IRQ = |(int_sts_r & int_mask_r);
endmodule

// ===== pts_pkg.sv
// Constants, register map and state types for the pulse-per-second sync selector
package pts_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int PPS_PERIOD_MS = 1000;
	localparam int PPS_CYCLES = PPS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PULSE_WIDTH_US = 100;
	localparam int PULSE_CYCLES = (PULSE_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] THRESH_RST = 32'h0000_0254;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_THRESH = 8'h08;
	localparam logic [7:0] REG_TOTAL = 8'h0c;
	localparam logic [7:0] REG_BAD = 8'h10;
	localparam logic [7:0] REG_SINGLES = 8'h14;
	localparam logic [7:0] REG_LONGEST = 8'h18;
	localparam logic [7:0] REG_FAILS = 8'h1c;
	localparam logic [7:0] REG_RESYNCS = 8'h20;
	localparam logic [7:0] REG_INT_STS = 8'h24;
	localparam logic [7:0] REG_INT_MASK = 8'h28;
	localparam logic [7:0] REG_PHASE = 8'h2c;

	// Control fields
	localparam int CTRL_IN_LSB = 0;
	localparam int CTRL_OUT_LSB = 2;
	localparam int CTRL_CLR_BIT = 4;
	localparam int CTRL_RST_BIT = 5;
	localparam logic [1:0] IN_NONE = 2'h0;
	localparam logic [1:0] IN_PORT = 2'h1;
	localparam logic [1:0] IN_HOST = 2'h2;
	localparam logic [1:0] OUT_NONE = 2'h0;
	localparam logic [1:0] OUT_PORT = 2'h1;
	localparam logic [1:0] OUT_LOOP = 2'h2;
	localparam logic [1:0] OUT_INT = 2'h3;

	// Status fields
	localparam int STS_SYNC_BIT = 0;
	localparam int STS_FREE_BIT = 1;
	localparam int STS_MASTER_BIT = 2;
	localparam int STS_STATE_LSB = 4;

	// Interrupt bits
	localparam int IRQ_W = 5;
	localparam int IRQ_PULSE = 0;
	localparam int IRQ_MISS = 1;
	localparam int IRQ_FAIL = 2;
	localparam int IRQ_RESYNC = 3;
	localparam int IRQ_BAD = 4;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Lock state, Gray coded along free, hunt, lock, lost
	typedef enum logic [1:0] {
		ST_FREE = 2'h0,
		ST_HUNT = 2'h1,
		ST_LOCK = 2'h3,
		ST_LOST = 2'h2
	} pts_sync_e;

endpackage

// ===== pts_stat_if.sv
// Event and counter bundle between the sync core and the statistics block
`timescale 1ns/1ns
interface pts_stat_if;
	logic clear;
	logic ev_pulse;
	logic ev_bad;
	logic ev_miss;
	logic ev_fail;
	logic ev_resync;
	logic [31:0] total;
	logic [31:0] bad;
	logic [31:0] singles;
	logic [31:0] longest;
	logic [31:0] fails;
	logic [31:0] resyncs;
	modport core (output clear, ev_pulse, ev_bad, ev_miss, ev_fail, ev_resync,
		input total, bad, singles, longest, fails, resyncs);
	modport stats (input clear, ev_pulse, ev_bad, ev_miss, ev_fail, ev_resync,
		output total, bad, singles, longest, fails, resyncs);
endinterface

// ===== pts_edge_sync.sv
// Two-stage synchronizer with a registered rising-edge pulse
`timescale 1ns/1ns
module pts_edge_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw input and results
	input wire logic din,
	output logic level,
	output logic rise
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic rise_r;

	// Two flops, then an edge detector on the settled copy
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			rise_r <= 1'b0;
		end
		else
		begin
			meta_r <= din;
			sync_r <= meta_r;
			prev_r <= sync_r;
			rise_r <= sync_r & ~prev_r;
		end
	end

	assign level = sync_r;
	assign rise = rise_r;
endmodule

// ===== pts_stats.sv
// Input pulse statistics counters
`timescale 1ns/1ns
module pts_stats
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Events in, counts out
	pts_stat_if.stats st
);
	logic [31:0] total_r, bad_r, singles_r, longest_r, fails_r, resyncs_r, run_r;
	logic [31:0] run_nxt;

	// Length of the current run of missed seconds
	assign run_nxt = st.ev_pulse ? 32'h0 : (st.ev_miss ? run_r + 32'h1 : run_r);

	// Counters, cleared together on request
	always_ff @(posedge clk)
	begin
		if (!rst_n || st.clear)
		begin
			total_r <= 32'h0;
			bad_r <= 32'h0;
			singles_r <= 32'h0;
			longest_r <= 32'h0;
			fails_r <= 32'h0;
			resyncs_r <= 32'h0;
			run_r <= 32'h0;
		end
		else
		begin
			total_r <= total_r + {31'h0, st.ev_pulse};
			bad_r <= bad_r + {31'h0, st.ev_bad};
			singles_r <= singles_r + {31'h0, st.ev_miss};
			fails_r <= fails_r + {31'h0, st.ev_fail};
			resyncs_r <= resyncs_r + {31'h0, st.ev_resync};
			run_r <= run_nxt;
			if (run_nxt > longest_r)
				longest_r <= run_nxt;
		end
	end

	assign st.total = total_r;
	assign st.bad = bad_r;
	assign st.singles = singles_r;
	assign st.longest = longest_r;
	assign st.fails = fails_r;
	assign st.resyncs = resyncs_r;
endmodule

// ===== pts_chk.sv
// Port-level assertions for the pulse sync selector
`timescale 1ns/1ns
module pts_chk #(
	parameter int CYCLES_PER_SEC = 4000,
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// Bus handshakes
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Pulse output and interrupt
	input wire logic PPS_TX_A_OE,
	input wire logic IRQ
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	////////////////////////////////////////////////////////////////////////////////
	// Reset and output enable
	a_rst_quiet: assert property (disable iff (1'b0)
		!NRST |=> !S_AXI_BVALID && !S_AXI_RVALID && !PPS_TX_A_OE && !IRQ)
		else $error("outputs active after reset");
	a_oe_cause: assert property ($rose(PPS_TX_A_OE) |->
		$past(S_AXI_BVALID, 1) || $past(S_AXI_BVALID, 2) || $past(S_AXI_BVALID, 3))
		else $error("pulse output enabled without a write");

	////////////////////////////////////////////////////////////////////////////////
	// Register bus
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
		else $error("read data dropped early");
	a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address taken while busy");
	a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered next cycle");
	a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |=> ##1 S_AXI_BVALID)
		else $error("write not answered in two cycles");
	a_rd_unmapped: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		(S_AXI_ARADDR > pts_pkg::REG_PHASE || S_AXI_ARADDR[1:0] != 2'h0) |=>
		S_AXI_RRESP == pts_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
		else $error("unmapped read not refused");
endmodule

bind pts_top pts_chk #(.CYCLES_PER_SEC(CYCLES_PER_SEC), .ADDR_W(ADDR_W)) i_chk (
	.MCLK(MCLK), .NRST(NRST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.PPS_TX_A_OE(PPS_TX_A_OE), .IRQ(IRQ));

// ===== pts_peer.sv
// Behavioural reference pulse source and peer card input
`timescale 1ns/1ns
module pts_peer #(
	parameter int PERIOD = 4000,
	parameter int WIDTH = 50
)
(
	// Clock and control
	input wire logic clk,
	input wire logic run,
	// Sync port circuit A
	output logic pps,
	input wire logic tx,
	input wire logic tx_oe,
	// Observations
	output int rises,
	output int width
);
	int cnt = 0;
	int hi = 0;

	initial
	begin
		pps = 1'b0;
		rises = 0;
		width = 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pulse source, line idles low outside pulses
	always @(posedge clk)
	begin
		cnt <= (run && cnt < PERIOD - 1) ? cnt + 1 : 0;
		pps <= run && cnt < WIDTH;
	end

	// Peer input, counts and times received pulses
	always @(posedge clk)
	begin
		hi <= (tx_oe && tx) ? hi + 1 : 0;
		if (tx_oe && tx && hi == 0)
			rises <= rises + 1;
		if (!tx && hi != 0)
			width <= hi;
	end
endmodule

// ===== tb_pps_time_sync_selector.sv
// Self-checking bench for the pulse sync selector
`timescale 1ns/1ns
module tb_pps_time_sync_selector;
	localparam int CPS = 4000;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic host_tick = 1'b0;
	logic run = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pps, tx, oe, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd, thr;
	logic [31:0] seed = 32'h297bf0e3;
	logic [3:0] m;
	logic [7:0] bad_addr [3] = '{8'h30, 8'h06, 8'hfc};
	int rises, width, r0, n_fail = 0, checked = 0, exp_total = 0;

	always #50 mclk = ~mclk;

	pts_top #(.CYCLES_PER_SEC(CPS)) i_dut (
		.MCLK(mclk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.PPS_RX_A(pps), .PPS_TX_A(tx), .PPS_TX_A_OE(oe), .HOST_TICK(host_tick), .IRQ(irq));
	pts_peer #(.PERIOD(CPS)) i_peer (.clk(mclk), .run(run), .pps(pps), .tx(tx),
		.tx_oe(oe), .rises(rises), .width(width));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus write, ready stalled at random
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		seed = xs(seed);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			bready <= !(bvalid && bready) && (seed[1] || n > 2);
		end
		while (!(bvalid && bready));
		cmp("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	// Bus read, ready stalled at random
	task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
		int n;
		n = 0;
		seed = xs(seed);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
			rready <= !(rvalid && rready) && (seed[0] || n > 1);
		end
		while (!(rvalid && rready));
		rd = rdata;
		cmp("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic ck(input string nm, input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
		rd_reg(a, pts_pkg::RESP_OKAY);
		cmp(nm, e, rd & k);
	endtask

	task automatic results;
		$display("compares %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#(80000 * 100);
		n_fail++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		cyc(1);
		cmp("oe", 32'h0, {31'h0, oe});
		ck("ctrl", pts_pkg::REG_CTRL, 32'hf, 32'h1);
		ck("thresh", pts_pkg::REG_THRESH, 32'hffffffff, pts_pkg::THRESH_RST);
		foreach (bad_addr[i])
		begin
			rd_reg(bad_addr[i], pts_pkg::RESP_SLVERR);
			cmp("bad data", 32'h0, rd);
			wr(bad_addr[i], 32'hffffffff, pts_pkg::RESP_SLVERR);
		end
		wr(pts_pkg::REG_TOTAL, 32'h5, pts_pkg::RESP_OKAY);
		$display("test defaults done");
		run <= 1'b1;
		cyc(2 * CPS + 100);
		exp_total = 3;
		ck("total", pts_pkg::REG_TOTAL, 32'hffffffff, exp_total);
		ck("status", pts_pkg::REG_STATUS, 32'h37, 32'h31);
		ck("int sts", pts_pkg::REG_INT_STS, 32'h1, 32'h1);
		cmp("irq", 32'h0, {31'h0, irq});
		wr(pts_pkg::REG_INT_MASK, 32'h1, pts_pkg::RESP_OKAY);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(pts_pkg::REG_INT_STS, 32'h1f, pts_pkg::RESP_OKAY);
		cmp("irq", 32'h0, {31'h0, irq});
		$display("test lock done");
		run <= 1'b0;
		cyc(2 * CPS);
		ck("singles", pts_pkg::REG_SINGLES, 32'hffffffff, 32'h1);
		ck("longest", pts_pkg::REG_LONGEST, 32'hffffffff, 32'h1);
		ck("fails", pts_pkg::REG_FAILS, 32'hffffffff, 32'h1);
		ck("status", pts_pkg::REG_STATUS, 32'h37, 32'h20);
		cmp("irq", 32'h0, {31'h0, irq});
		wr(pts_pkg::REG_INT_MASK, 32'h1f, pts_pkg::RESP_OKAY);
		cmp("irq", 32'h1, {31'h0, irq});
		run <= 1'b1;
		cyc(2 * CPS + 100);
		exp_total += 3;
		ck("total", pts_pkg::REG_TOTAL, 32'hffffffff, exp_total);
		ck("resyncs", pts_pkg::REG_RESYNCS, 32'hffffffff, 32'h1);
		ck("status", pts_pkg::REG_STATUS, 32'h37, 32'h31);
		$display("test miss and resync done");
		run <= 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			m = i[3:0];
			wr(pts_pkg::REG_CTRL, {28'h0, m}, pts_pkg::RESP_OKAY);
			cyc(2);
			cmp("oe", {31'h0, m[3:2] != 2'h0}, {31'h0, oe});
			ck("status", pts_pkg::REG_STATUS, 32'h6, {29'h0, m[3:2] == 2'h3,
				m[1:0] == 2'h0 || m[1:0] == 2'h3, 1'b0});
		end
		$display("test modes done");
		wr(pts_pkg::REG_CTRL, 32'hc, pts_pkg::RESP_OKAY);
		cyc(CPS);
		r0 = rises;
		cyc(2 * CPS);
		cmp("rises", 32'h2, rises - r0);
		cmp("width", pts_pkg::PULSE_CYCLES, width);
		ck("status", pts_pkg::REG_STATUS, 32'h37, 32'h6);
		wr(pts_pkg::REG_CTRL, 32'he, pts_pkg::RESP_OKAY);
		repeat (3)
		begin
			host_tick <= 1'b1;
			cyc(1);
			host_tick <= 1'b0;
			cyc(CPS - 1);
		end
		ck("status", pts_pkg::REG_STATUS, 32'h37, 32'h35);
		cmp("oe", 32'h1, {31'h0, oe});
		$display("test master done");
		seed = xs(seed);
		thr = 32'h100 + (seed & 32'h3ff);
		wr(pts_pkg::REG_THRESH, thr, pts_pkg::RESP_OKAY);
		ck("thresh", pts_pkg::REG_THRESH, 32'hffffffff, thr);
		wr(pts_pkg::REG_CTRL, 32'h1e, pts_pkg::RESP_OKAY);
		ck("total", pts_pkg::REG_TOTAL, 32'hffffffff, 32'h0);
		wr(pts_pkg::REG_CTRL, 32'h20, pts_pkg::RESP_OKAY);
		cyc(2);
		cmp("oe", 32'h0, {31'h0, oe});
		ck("ctrl", pts_pkg::REG_CTRL, 32'hf, 32'h1);
		ck("thresh", pts_pkg::REG_THRESH, 32'hffffffff, thr);
		$display("test full reset done");
		results();
	end
endmodule
